// ==== logic/iofd_pkg.sv ====
// constants shared by the instruction operand field decoder
package iofd_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int OSC_PER_CYCLE = 4;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_TBL_PTR = 8'h08;
  localparam logic [7:0] OFS_PROD = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_TARGET = 8'h14;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int PROGRAM_TABLE_POINTER_W = 21;
  localparam int MOVE_W = 14;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [20:0] RST_TBL_PTR = 21'h00_0000;
  localparam logic [7:0] RST_PROD = 8'h00;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;

  // ---------------------------------------------------------------
  // instruction field positions
  // ---------------------------------------------------------------
  localparam int POS_DEST = 9;
  localparam int POS_ACCESS = 8;
  localparam int POS_FAST_CALL = 8;
  localparam int POS_FAST_RET = 0;
  localparam int POS_BIT_LO = 9;
  localparam logic [3:0] NIB_CONT = 4'hF;

  // ---------------------------------------------------------------
  // table pointer modes
  // ---------------------------------------------------------------
  localparam logic [1:0] TBL_KEEP = 2'b00;
  localparam logic [1:0] TBL_POSTINC = 2'b01;
  localparam logic [1:0] TBL_POSTDEC = 2'b10;
  localparam logic [1:0] TBL_PREINC = 2'b11;

  // ---------------------------------------------------------------
  // word sequencer, gray along first-second-third
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_FIRST = 2'b00,
    SEQ_SECOND = 2'b01,
    SEQ_THIRD = 2'b11
  } iofd_seq_e;

  // multi-word instruction kinds
  typedef enum logic [1:0] {
    MW_MOVE2 = 2'b00,
    MW_MOVE3 = 2'b01,
    MW_GOTO = 2'b10,
    MW_CALL = 2'b11
  } iofd_mw_e;

endpackage

// ==== logic/iofd_cycle_div.sv ====
// instruction cycle enable divider
`timescale 1ns/10ps
`default_nettype none

module iofd_cycle_div #(
  parameter int DIV = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // one pulse per instruction cycle
  output logic cyc_en
);

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_cyc_en;

  always_comb begin
    next_cyc_en = 1'b0;
    next_cnt = cnt + 8'h01;
    if (cnt == 8'(DIV - 1)) begin
      next_cnt = 8'h00;
      next_cyc_en = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt <= 8'h00;
      cyc_en <= 1'b0;
    end else begin
      cnt <= next_cnt;
      cyc_en <= next_cyc_en;
    end
  end

endmodule
`default_nettype wire

// ==== logic/iofd_decoder.sv ====
// operand field decoder with apb register slave
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none

//
// Behaviour
// - d=0 writes result to accumulator, d=1 writes to the file register.
// - a=0 addresses access bank ignoring bank select; a=1 uses bank select.
// - s=0 leaves shadows alone; s=1 saves or restores via shadow copies.
// - relative branch operand is signed; call/goto operand is absolute.
// - 8-bit file address combined with bank selection forms operand address.
// - two-word move takes 12-bit source and destination, one per word.
// - 3-bit field picks bit 0 to 7 of the addressed register.
// - literal load takes an 8-bit immediate from the instruction word.
// - table pointer is 21 bits and addresses program memory.
// - multiply puts high byte in product high, low byte in product low.
// - don't care bits are ignored whatever their value.
// - continuation words have top nibble set; alone they act as no-op.
// - one instruction cycle is four clocks; branches take two cycles, except conditional ones (top nibble E, bit 11 clear), which take one.
module iofd_decoder #(
  parameter int CYCLE_DIV = iofd_pkg::OSC_PER_CYCLE
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // program memory
  input wire logic [15:0] prog_word,
  input wire logic prog_valid,
  output logic fetch_req,
  // register file data
  input wire logic [7:0] file_rd_data,
  // datapath control
  output logic acc_we,
  output logic file_we,
  output logic [11:0] ram_addr,
  output logic [2:0] bit_pos,
  output logic [7:0] bit_mask,
  output logic [7:0] literal,
  output logic shadow_save,
  output logic shadow_restore,
  output logic move_go,
  output logic [13:0] move_src,
  output logic [13:0] move_dst,
  // program counter control
  output logic pc_load,
  output logic pc_rel,
  output logic [20:0] pc_value,
  output logic [1:0] exec_cycles,
  output logic nop_exec,
  // table and product
  output logic [20:0] table_addr,
  output logic [7:0] product_high_register,
  output logic [7:0] product_low_register
);

  // ---------------------------------------------------------------
  // instruction cycle enable
  // ---------------------------------------------------------------
  logic cyc_en;

  iofd_cycle_div #(
    .DIV(CYCLE_DIV)
  ) u_div (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .cyc_en(cyc_en)
  );

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  logic [3:0] bank_select_register;
  logic [7:0] working_accumulator;
  logic [20:0] program_table_pointer;
  logic [31:0] status_word;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [3:0] next_bank;
  logic apb_acc_wr;
  logic apb_tbl_wr;
  logic apb_hit;

  always_comb begin
    next_pready = psel & penable & ~pready;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    next_bank = bank_select_register;
    apb_acc_wr = 1'b0;
    apb_tbl_wr = 1'b0;
    apb_hit = 1'b1;
    case (paddr)
      iofd_pkg::OFS_CTRL: next_prdata = {28'h000_0000, bank_select_register};
      iofd_pkg::OFS_ACC: next_prdata = {24'h00_0000, working_accumulator};
      iofd_pkg::OFS_TBL_PTR: next_prdata = {11'h000, program_table_pointer};
      iofd_pkg::OFS_PROD: next_prdata = {16'h0000, product_high_register,
                                         product_low_register};
      iofd_pkg::OFS_STATUS: next_prdata = status_word;
      iofd_pkg::OFS_TARGET: next_prdata = {11'h000, pc_value};
      default: apb_hit = 1'b0;
    endcase
    if (next_pready) begin
      next_pslverr = ~apb_hit;
      if (pwrite) begin
        next_prdata = 32'h0000_0000;
      end
    end else begin
      next_prdata = prdata;
    end
    if (psel && penable && pready && pwrite) begin
      if (paddr == iofd_pkg::OFS_CTRL) begin
        next_bank = pwdata[3:0];
      end
      apb_acc_wr = (paddr == iofd_pkg::OFS_ACC);
      apb_tbl_wr = (paddr == iofd_pkg::OFS_TBL_PTR);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      bank_select_register <= iofd_pkg::RST_BANK;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      bank_select_register <= next_bank;
    end
  end

  // ---------------------------------------------------------------
  // instruction latch and word sequencer
  // ---------------------------------------------------------------
  iofd_pkg::iofd_seq_e seq;
  iofd_pkg::iofd_seq_e next_seq;
  iofd_pkg::iofd_mw_e mw_kind;
  iofd_pkg::iofd_mw_e next_mw_kind;
  logic [15:0] iw;
  logic [15:0] next_iw;
  logic [15:0] w1;
  logic [15:0] next_w1;
  logic [15:0] w2;
  logic [15:0] next_w2;
  logic dec_go;
  logic next_dec_go;
  logic mul_pend;
  logic next_mul_pend;
  logic [7:0] mul_opnd;
  logic [7:0] next_mul_opnd;
  logic mul_from_file;
  logic next_mul_from_file;
  logic [7:0] next_acc;
  logic [20:0] next_program_table_pointer;
  logic [15:0] product;

  // decoded next values of outputs
  logic next_acc_we;
  logic next_file_we;
  logic [11:0] next_ram_addr;
  logic [2:0] next_bit_pos;
  logic [7:0] next_bit_mask;
  logic [7:0] next_literal;
  logic next_shadow_save;
  logic next_shadow_restore;
  logic next_move_go;
  logic [13:0] next_move_src;
  logic [13:0] next_move_dst;
  logic next_pc_load;
  logic next_pc_rel;
  logic [20:0] next_pc_value;
  logic [1:0] next_exec_cycles;
  logic next_nop_exec;
  logic [20:0] next_table_addr;
  logic [7:0] next_prod_hi;
  logic [7:0] next_prod_lo;
  logic [7:0] f_field;
  logic access_a;

  assign f_field = iw[7:0];
  assign access_a = iw[iofd_pkg::POS_ACCESS];
  assign product = 16'(working_accumulator *
                       (mul_from_file ? file_rd_data : mul_opnd));
  assign status_word = {14'h0000, seq, exec_cycles, shadow_save,
                        shadow_restore, nop_exec, bit_pos, literal};

  always_comb begin
    next_seq = seq;
    next_mw_kind = mw_kind;
    next_iw = iw;
    next_w1 = w1;
    next_w2 = w2;
    next_dec_go = 1'b0;
    next_mul_pend = 1'b0;
    next_mul_opnd = mul_opnd;
    next_mul_from_file = mul_from_file;
    next_acc = working_accumulator;
    next_program_table_pointer = program_table_pointer;
    next_acc_we = 1'b0;
    next_file_we = 1'b0;
    next_ram_addr = ram_addr;
    next_bit_pos = bit_pos;
    next_bit_mask = bit_mask;
    next_literal = literal;
    next_shadow_save = 1'b0;
    next_shadow_restore = 1'b0;
    next_move_go = 1'b0;
    next_move_src = move_src;
    next_move_dst = move_dst;
    next_pc_load = 1'b0;
    next_pc_rel = 1'b0;
    next_pc_value = pc_value;
    next_exec_cycles = exec_cycles;
    next_nop_exec = 1'b0;
    next_table_addr = table_addr;
    next_prod_hi = product_high_register;
    next_prod_lo = product_low_register;

    // latch a word once per instruction cycle
    if (cyc_en && prog_valid) begin
      next_iw = prog_word;
      next_dec_go = 1'b1;
    end

    // multiply result one clock after the operand address is out
    if (mul_pend) begin
      next_prod_hi = product[15:8];
      next_prod_lo = product[7:0];
    end
    if (mul_from_file && mul_pend) begin
      next_mul_opnd = file_rd_data;
    end

    if (dec_go) begin
      next_exec_cycles = 2'd1;
      // access bank or banked operand address
      if (access_a) begin
        next_ram_addr = {bank_select_register, f_field};
      end else if (f_field >= iofd_pkg::ACCESS_SPLIT) begin
        next_ram_addr = {iofd_pkg::ACCESS_HI_BANK, f_field};
      end else begin
        next_ram_addr = {4'h0, f_field};
      end
      case (seq)
        iofd_pkg::SEQ_SECOND: begin
          next_w2 = iw;
          if (mw_kind == iofd_pkg::MW_MOVE2) begin
            next_move_src = {2'b00, w1[11:0]};
            next_move_dst = {2'b00, iw[11:0]};
            next_exec_cycles = 2'd2;
            next_move_go = 1'b1;
            next_seq = iofd_pkg::SEQ_FIRST;
          end else if (mw_kind == iofd_pkg::MW_MOVE3) begin
            next_seq = iofd_pkg::SEQ_THIRD;
          end else begin
            next_pc_value = {1'b0, iw[11:0], w1[7:0]};
            next_pc_load = 1'b1;
            next_exec_cycles = 2'd2;
            next_shadow_save = (mw_kind == iofd_pkg::MW_CALL) &&
                               w1[iofd_pkg::POS_FAST_CALL];
            next_seq = iofd_pkg::SEQ_FIRST;
          end
        end
        iofd_pkg::SEQ_THIRD: begin
          next_move_src = {w1[3:0], w2[11:2]};
          next_move_dst = {w2[1:0], iw[11:0]};
          next_move_go = 1'b1;
          next_exec_cycles = 2'd3;
          next_seq = iofd_pkg::SEQ_FIRST;
        end
        default: begin
          next_w1 = iw;
          next_seq = iofd_pkg::SEQ_FIRST;
          case (iw[15:12])
            4'h0: begin
              if (iw[11:8] == 4'hE) begin
                next_literal = iw[7:0];
                next_acc = iw[7:0];
              end else if (iw[11:8] == 4'hD) begin
                next_literal = iw[7:0];
                next_mul_opnd = iw[7:0];
                next_mul_from_file = 1'b0;
                next_mul_pend = 1'b1;
              end else if (iw[11:9] == 3'b001) begin
                next_mul_from_file = 1'b1;
                next_mul_pend = 1'b1;
              end else if (iw[11:10] == 2'b01) begin
                next_acc_we = ~iw[iofd_pkg::POS_DEST];
                next_file_we = iw[iofd_pkg::POS_DEST];
              end else if (iw[11:4] == 8'h00) begin
                case (iw[3:0])
                  4'h0: next_nop_exec = 1'b1;
                  4'h8, 4'h9, 4'hA, 4'hB,
                  4'hC, 4'hD, 4'hE, 4'hF: begin
                    case (iw[1:0])
                      iofd_pkg::TBL_POSTINC:
                        next_program_table_pointer = program_table_pointer + 21'd1;
                      iofd_pkg::TBL_POSTDEC:
                        next_program_table_pointer = program_table_pointer - 21'd1;
                      iofd_pkg::TBL_PREINC:
                        next_program_table_pointer = program_table_pointer + 21'd1;
                      default: next_program_table_pointer = program_table_pointer;
                    endcase
                    next_table_addr = (iw[1:0] == iofd_pkg::TBL_PREINC) ?
                      program_table_pointer + 21'd1 :
                      program_table_pointer;
                    next_exec_cycles = 2'd2;
                  end
                  default: next_nop_exec = 1'b1;
                endcase
              end else if (iw[11:1] == 11'h008 || iw[11:1] == 11'h009) begin
                next_shadow_restore = iw[iofd_pkg::POS_FAST_RET];
                next_pc_load = 1'b1;
                next_exec_cycles = 2'd2;
              end else if (iw[11:4] == 8'h06) begin
                next_mw_kind = iofd_pkg::MW_MOVE3;
                next_seq = iofd_pkg::SEQ_SECOND;
              end else begin
                next_nop_exec = 1'b1;
              end
            end
            4'h1, 4'h2, 4'h3, 4'h4, 4'h5: begin
              next_acc_we = ~iw[iofd_pkg::POS_DEST];
              next_file_we = iw[iofd_pkg::POS_DEST];
            end
            4'h6: begin
              next_file_we = iw[11:9] == 3'b111;
            end
            4'h7, 4'h8, 4'h9, 4'hA, 4'hB: begin
              next_bit_pos = iw[iofd_pkg::POS_BIT_LO +: 3];
              next_bit_mask = 8'h01 << iw[iofd_pkg::POS_BIT_LO +: 3];
              next_file_we = iw[15:12] != 4'hA && iw[15:12] != 4'hB;
            end
            4'hC: begin
              next_mw_kind = iofd_pkg::MW_MOVE2;
              next_seq = iofd_pkg::SEQ_SECOND;
            end
            4'hD: begin
              next_pc_value = {{10{iw[10]}}, iw[10:0]};
              next_pc_rel = 1'b1;
              next_shadow_save = 1'b0;
              next_exec_cycles = 2'd2;
            end
            4'hE: begin
              if (iw[11] == 1'b0) begin
                next_pc_value = {{13{iw[7]}}, iw[7:0]};
                next_pc_rel = 1'b1;
              end else if (iw[11:9] == 3'b110) begin
                next_mw_kind = iofd_pkg::MW_CALL;
                next_seq = iofd_pkg::SEQ_SECOND;
              end else if (iw[11:8] == 4'hF) begin
                next_mw_kind = iofd_pkg::MW_GOTO;
                next_seq = iofd_pkg::SEQ_SECOND;
              end else begin
                next_nop_exec = 1'b1;
              end
            end
            default: next_nop_exec = 1'b1;
          endcase
        end
      endcase
    end

    if (apb_acc_wr) begin
      next_acc = pwdata[7:0];
    end
    if (apb_tbl_wr) begin
      next_program_table_pointer = pwdata[20:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      seq <= iofd_pkg::SEQ_FIRST;
      mw_kind <= iofd_pkg::MW_MOVE2;
      iw <= 16'h0000;
      w1 <= 16'h0000;
      w2 <= 16'h0000;
      dec_go <= 1'b0;
      mul_pend <= 1'b0;
      mul_opnd <= 8'h00;
      mul_from_file <= 1'b0;
      working_accumulator <= iofd_pkg::RST_ACC;
      program_table_pointer <= iofd_pkg::RST_TBL_PTR;
      fetch_req <= 1'b0;
      acc_we <= 1'b0;
      file_we <= 1'b0;
      ram_addr <= 12'h000;
      bit_pos <= 3'd0;
      bit_mask <= 8'h01;
      literal <= 8'h00;
      shadow_save <= 1'b0;
      shadow_restore <= 1'b0;
      move_go <= 1'b0;
      move_src <= 14'h0000;
      move_dst <= 14'h0000;
      pc_load <= 1'b0;
      pc_rel <= 1'b0;
      pc_value <= 21'h00_0000;
      exec_cycles <= 2'd1;
      nop_exec <= 1'b0;
      table_addr <= iofd_pkg::RST_TBL_PTR;
      product_high_register <= iofd_pkg::RST_PROD;
      product_low_register <= iofd_pkg::RST_PROD;
    end else begin
      seq <= next_seq;
      mw_kind <= next_mw_kind;
      iw <= next_iw;
      w1 <= next_w1;
      w2 <= next_w2;
      dec_go <= next_dec_go;
      mul_pend <= next_mul_pend;
      mul_opnd <= next_mul_opnd;
      mul_from_file <= next_mul_from_file;
      working_accumulator <= next_acc;
      program_table_pointer <= next_program_table_pointer;
      fetch_req <= cyc_en;
      acc_we <= next_acc_we;
      file_we <= next_file_we;
      ram_addr <= next_ram_addr;
      bit_pos <= next_bit_pos;
      bit_mask <= next_bit_mask;
      literal <= next_literal;
      shadow_save <= next_shadow_save;
      shadow_restore <= next_shadow_restore;
      move_go <= next_move_go;
      move_src <= next_move_src;
      move_dst <= next_move_dst;
      pc_load <= next_pc_load;
      pc_rel <= next_pc_rel;
      pc_value <= next_pc_value;
      exec_cycles <= next_exec_cycles;
      nop_exec <= next_nop_exec;
      table_addr <= next_table_addr;
      product_high_register <= next_prod_hi;
      product_low_register <= next_prod_lo;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/iofd_decoder_props.sv ====
// assertion checker for the operand field decoder
`timescale 1ns/10ps
`default_nettype none

module iofd_decoder_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // control pulses
  input wire logic fetch_req,
  input wire logic acc_we,
  input wire logic file_we,
  input wire logic shadow_save,
  input wire logic shadow_restore,
  input wire logic move_go,
  input wire logic pc_load,
  input wire logic pc_rel,
  input wire logic nop_exec,
  // field levels
  input wire logic [2:0] bit_pos,
  input wire logic [7:0] bit_mask,
  input wire logic [1:0] exec_cycles
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  property p_dest_excl;
    !(acc_we && file_we);
  endproperty
  a_dest_excl: assert property (p_dest_excl) else $error("two dests");
  property p_save_call;
    shadow_save |-> pc_load && !pc_rel;
  endproperty
  a_save_call: assert property (p_save_call) else $error("save");
  property p_restore_ret;
    shadow_restore |-> pc_load && !shadow_save;
  endproperty
  a_restore_ret: assert property (p_restore_ret) else $error("rest");
  property p_rel_abs;
    pc_rel |-> !pc_load;
  endproperty
  a_rel_abs: assert property (p_rel_abs) else $error("rel and abs");
  property p_rel_two;
    pc_rel |-> exec_cycles == 2'd2;
  endproperty
  a_rel_two: assert property (p_rel_two) else $error("branch cyc");
  property p_move_cyc;
    move_go |-> exec_cycles != 2'd1;
  endproperty
  a_move_cyc: assert property (p_move_cyc) else $error("move cyc");
  property p_bit_mask;
    bit_mask == (8'h01 << bit_pos);
  endproperty
  a_bit_mask: assert property (p_bit_mask) else $error("bit mask");
  property p_nop_quiet;
    nop_exec |-> !(acc_we || file_we || pc_load || pc_rel || move_go);
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("nop act");
  property p_cycle_four;
    fetch_req |=> !fetch_req [*3] ##1 fetch_req;
  endproperty
  a_cycle_four: assert property (p_cycle_four) else $error("cyc");
  property p_pulse_once;
    (acc_we || file_we) |=> !(acc_we || file_we);
  endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("pulse");
endmodule

bind iofd_decoder iofd_decoder_props u_props (.sys_clk, .reset_n,
  .fetch_req, .acc_we, .file_we, .shadow_save, .shadow_restore, .move_go,
  .pc_load, .pc_rel, .nop_exec, .bit_pos, .bit_mask, .exec_cycles);

`default_nettype wire

// ==== testbench/iofd_prog_mem.sv ====
// program memory model answering fetch requests
`timescale 1ns/10ps
`default_nettype none

module iofd_prog_mem (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // bench side
  input wire logic [15:0] next_word,
  input wire logic next_ok,
  // decoder side
  input wire logic fetch_req,
  output logic [15:0] prog_word,
  output logic prog_valid
);
  // a missed slot shows the inverted old word, never a stale copy
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prog_word <= 16'h0000;
      prog_valid <= 1'b0;
    end else if (fetch_req) begin
      prog_valid <= next_ok;
      prog_word <= next_ok ? next_word : ~prog_word;
    end
  end
endmodule

`default_nettype wire

// ==== testbench/instruction_operand_field_decoder_bench.sv ====
// self-checking bench for the operand field decoder
`timescale 1ns/10ps
`default_nettype none

module instruction_operand_field_decoder_bench;
  typedef struct {
    int n;
    logic [47:0] w;
    logic [7:0] pm;
    logic [7:0] pe;
    logic [2:0] sel;
    logic [27:0] val;
    logic [1:0] cyc;
  } iofd_row_s;
  // pulse bits: acc file save restore move load rel nop
  iofd_row_s rows [17] = '{
    '{1, 48'h2412_0000_0000, 8'hc1, 8'h80, 3'd0, 28'h000_0012, 2'd1},
    '{1, 48'h2680_0000_0000, 8'hc1, 8'h40, 3'd0, 28'h000_0f80, 2'd1},
    '{1, 48'h2734_0000_0000, 8'hc1, 8'h40, 3'd0, 28'h000_0534, 2'd1},
    '{1, 48'h8e20_0000_0000, 8'h01, 8'h00, 3'd1, 28'h000_0007, 2'd1},
    '{1, 48'h8a20_0000_0000, 8'h01, 8'h00, 3'd5, 28'h000_0020, 2'd1},
    '{1, 48'h0e7f_0000_0000, 8'h41, 8'h00, 3'd2, 28'h000_007f, 2'd1},
    '{1, 48'hfabc_0000_0000, 8'hcf, 8'h01, 3'd7, 28'h000_0000, 2'd0},
    '{1, 48'hf000_0000_0000, 8'hcf, 8'h01, 3'd7, 28'h000_0000, 2'd0},
    '{2, 48'hec34_f012_0000, 8'h24, 8'h04, 3'd3, 28'h000_1234, 2'd2},
    '{2, 48'hed34_f012_0000, 8'h24, 8'h24, 3'd3, 28'h000_1234, 2'd2},
    '{2, 48'hef56_f078_0000, 8'h06, 8'h04, 3'd3, 28'h000_7856, 2'd2},
    '{1, 48'h0013_0000_0000, 8'h14, 8'h14, 3'd7, 28'h000_0000, 2'd2},
    '{1, 48'h0012_0000_0000, 8'h14, 8'h04, 3'd7, 28'h000_0000, 2'd2},
    '{1, 48'hd7fe_0000_0000, 8'h06, 8'h02, 3'd3, 28'h01f_fffe, 2'd2},
    '{1, 48'hd005_0000_0000, 8'h06, 8'h02, 3'd3, 28'h000_0005, 2'd2},
    '{2, 48'hc123_f456_0000, 8'h09, 8'h08, 3'd4, 28'h048_c456, 2'd2},
    '{3, 48'h006a_faf3_f456, 8'h09, 8'h08, 3'd4, 28'haaf_3456, 2'd3}
  };
  logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, re;
  logic [7:0] paddr, file_rd_data, bit_mask, literal, st;
  logic [7:0] product_high_register, product_low_register;
  logic [31:0] pwdata, prdata, rq;
  logic [15:0] prog_word, nw;
  logic prog_valid, fetch_req, nok, clr, acc_we, file_we, shadow_save;
  logic shadow_restore, move_go, pc_load, pc_rel, nop_exec;
  logic [11:0] ram_addr;
  logic [2:0] bit_pos;
  logic [13:0] move_src, move_dst;
  logic [20:0] pc_value, table_addr;
  logic [1:0] exec_cycles;
  int num_errors = 0;
  int num_checks = 0;
  int tick = 0;

  iofd_decoder u_dut (.sys_clk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .prog_word, .prog_valid,
    .fetch_req, .file_rd_data, .acc_we, .file_we, .ram_addr, .bit_pos,
    .bit_mask, .literal, .shadow_save, .shadow_restore, .move_go,
    .move_src, .move_dst, .pc_load, .pc_rel, .pc_value, .exec_cycles,
    .nop_exec, .table_addr, .product_high_register, .product_low_register);
  iofd_prog_mem u_mem (.sys_clk, .reset_n, .next_word(nw), .next_ok(nok),
    .fetch_req, .prog_word, .prog_valid);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ---------------------------------------------------------------
  // pulse capture and timeout
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (clr) st <= 8'h00;
    else st <= st | {acc_we, file_we, shadow_save, shadow_restore,
                     move_go, pc_load, pc_rel, nop_exec};
    tick <= tick + 1;
    if (tick == 20000) begin
      num_errors = num_errors + 1;
      end_sim();
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic send(input int n, input logic [47:0] w);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    for (int i = 0; i < n; i++) begin
      nw <= w[47-16*i -: 16];
      nok <= 1'b1;
      do @(posedge sys_clk); while (fetch_req !== 1'b1);
    end
    nok <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
  function automatic logic [31:0] pick(input logic [2:0] s);
    case (s)
      3'd0: pick = {20'h0_0000, ram_addr};
      3'd1: pick = {29'h0000_0000, bit_pos};
      3'd2: pick = {24'h00_0000, literal};
      3'd3: pick = {11'h000, pc_value};
      3'd4: pick = {4'h0, move_src, move_dst};
      3'd5: pick = {24'h00_0000, bit_mask};
      default: pick = 32'h0000_0000;
    endcase
  endfunction
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, nok, clr} = 5'b00001;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    file_rd_data = 8'h5a;
    nw = 16'h0000;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    chk(bit_mask, 32'h0000_0001);
    chk(exec_cycles, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0000_0000);
      chk(rq, 32'h0000_0000);
    end
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk({re, rq[30:0]}, 32'h8000_0000);
    apb(1'b1, iofd_pkg::OFS_CTRL, 32'h0000_0005);
    apb(1'b0, iofd_pkg::OFS_CTRL, 32'h0000_0000);
    chk(rq, 32'h0000_0005);
    for (int i = 0; i < 17; i++) begin
      send(rows[i].n, rows[i].w);
      chk(st & rows[i].pm, rows[i].pe);
      chk(pick(rows[i].sel), rows[i].val);
      if (rows[i].cyc != 2'd0) chk(exec_cycles, rows[i].cyc);
    end
    send(1, 48'h0e7f_0000_0000);
    apb(1'b0, iofd_pkg::OFS_ACC, 32'h0000_0000);
    chk(rq, 32'h0000_007f);
    apb(1'b0, iofd_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rq, 32'h0000_457f);
    apb(1'b0, iofd_pkg::OFS_TARGET, 32'h0000_0000);
    chk(rq, 32'h0000_0005);
    apb(1'b1, iofd_pkg::OFS_ACC, 32'h0000_00c3);
    send(1, 48'h0212_0000_0000);
    chk({product_high_register, product_low_register}, 32'h448e);
    apb(1'b0, iofd_pkg::OFS_PROD, 32'h0000_0000);
    chk(rq, 32'h0000_448e);
    apb(1'b1, iofd_pkg::OFS_TBL_PTR, 32'hffff_ffff);
    apb(1'b0, iofd_pkg::OFS_TBL_PTR, 32'h0000_0000);
    chk(rq, 32'h001f_ffff);
    send(1, 48'h0008_0000_0000);
    chk(table_addr, 32'h001f_ffff);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    chk({exec_cycles, bit_mask, table_addr}, 32'h2020_0000);
    apb(1'b0, iofd_pkg::OFS_CTRL, 32'h0000_0000);
    chk(rq, 32'h0000_0000);
    end_sim();
  end
endmodule

`default_nettype wire
